//--- common/decim_pkg.sv
// constants for the decimation chain: rates, widths, settle counts
// assumes a single pclk domain; master clock enable comes from outside
package decim_pkg;
  localparam int unsigned MOD_W       = 8;    // modulator word width
  localparam int unsigned OUT_W       = 24;   // result width
  localparam int unsigned ACC_W       = 40;
  localparam int unsigned S1_DEC      = 4;
  localparam int unsigned S2_DEC_FAST = 16;
  localparam int unsigned S2_DEC_SLOW = 32;
  localparam int unsigned S3_DEC      = 2;
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned INTERNAL_MODULATOR_CLOCK_DIV_NORM = 2;  // mclk/2
  localparam int unsigned INTERNAL_MODULATOR_CLOCK_DIV_LOW  = 4;  // mclk/4
  localparam int unsigned SETTLE_128  = 14217; // master clock periods
  localparam int unsigned SETTLE_256  = 27895;
  localparam int unsigned SETTLE_W    = 15;
  // apb register offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;
  localparam logic [7:0] DATA_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_OFS    = 8'h10;
  // ctrl bits
  localparam int unsigned CTRL_LPWR = 0;
  localparam int unsigned CTRL_SYNC = 1;
  // irq bits
  localparam int unsigned IRQ_DRDY   = 0;
  localparam int unsigned IRQ_SETTLE = 1;
  localparam int unsigned IRQ_OVR    = 2;
  localparam int unsigned IRQ_W      = 3;
endpackage : decim_pkg

//--- design/decim_chain.sv
// decimation chain behind a multibit modulator, with apb status access
// assumes mclk_en pulses once per master clock; mod_data is synchronous
// How it works
// - stage one takes each word, decimates by four
// - stage two decimates by sixteen or thirty-two
// - stage three always decimates by two
// - whole chain decimates 128 or 256
// - normal power: modulator rate is mclk/2
// - low power: modulator rate is mclk/4
// - settle flag after 14217 or 27895 periods
// - results are 24-bit two's complement
// - falling sync edge clears the filter
// - powerdown low holds the filter, settle counter and modulator clock cleared
// - settle flag drops on reset, sync, overrange
// - select high gives 128, low 256
//
// The placing of the registers and register access over APB were chosen for this implementation.
module decim_chain (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // device pins
  input  wire logic                        reset_powerdown_n,
  input  wire logic                        sync_n,
  input  wire logic                        decimation_select,
  input  wire logic                        overrange,
  input  wire logic                        mclk_en,
  // modulator
  input  wire logic signed [decim_pkg::MOD_W-1:0] mod_data,
  // results
  output logic                             result_valid,
  output logic [decim_pkg::OUT_W-1:0]      result_data,
  output logic                             filter_settled_flag,
  output logic                             internal_modulator_clock,
  // apb
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // interrupt
  output logic                             irq
);
  // pin synchronisers
  logic [1:0] pd_s_r;
  logic [1:0] sync_s_r;
  logic [1:0] dec_s_r;
  logic [1:0] ovr_s_r;
  logic       sync_d_r;
  logic       pd_run;
  logic       sync_fall;
  logic       clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_s_r   <= '0;
      sync_s_r <= 2'b11;
      dec_s_r  <= '0;
      ovr_s_r  <= '0;
      sync_d_r <= 1'b1;
    end else begin
      pd_s_r   <= {pd_s_r[0], reset_powerdown_n};
      sync_s_r <= {sync_s_r[0], sync_n};
      dec_s_r  <= {dec_s_r[0], decimation_select};
      ovr_s_r  <= {ovr_s_r[0], overrange};
      sync_d_r <= sync_s_r[1];
    end
  end

  assign pd_run    = pd_s_r[1];
  assign sync_fall = sync_d_r && !sync_s_r[1];
  logic  sw_sync;
  assign clr       = !pd_run || sync_fall || sw_sync;

  // ratio latched only when the filter is cleared; the extra cycle
  // catches the select pin once its synchroniser is valid after reset
  logic dec128_r;
  logic clr_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      clr_d_r <= 1'b1;
    else
      clr_d_r <= clr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dec128_r <= 1'b0;
    else if (clr || clr_d_r)
      dec128_r <= dec_s_r[1];
  end

  // control register
  logic lpwr_r;
  logic apb_wr;
  logic apb_rd;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign sw_sync = apb_wr && (paddr == decim_pkg::CTRL_OFS)
                   && pwdata[decim_pkg::CTRL_SYNC];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lpwr_r <= 1'b0;
    else if (apb_wr && paddr == decim_pkg::CTRL_OFS)
      lpwr_r <= pwdata[decim_pkg::CTRL_LPWR];
  end

  // modulator clock enable
  logic internal_modulator_clock_en;
  internal_modulator_clock_gen u_internal_modulator_clock (
    .pclk      (pclk),
    .presetn   (presetn),
    .clr       (clr),
    .low_power (lpwr_r),
    .mclk_en   (mclk_en),
    .internal_modulator_clock_en   (internal_modulator_clock_en)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      internal_modulator_clock <= 1'b0;
    else if (clr)
      internal_modulator_clock <= 1'b0;
    else if (internal_modulator_clock_en)
      internal_modulator_clock <= !internal_modulator_clock;
  end

  // three stages in series
  logic signed [decim_pkg::ACC_W-1:0] s_data [0:3];
  logic                               s_valid [0:3];
  logic [decim_pkg::CNT_W-1:0]        s_last [0:2];

  assign s_valid[0] = internal_modulator_clock_en;
  assign s_data[0]  = decim_pkg::ACC_W'(mod_data);
  assign s_last[0]  = decim_pkg::CNT_W'(decim_pkg::S1_DEC - 1);
  assign s_last[1]  = dec128_r
                    ? decim_pkg::CNT_W'(decim_pkg::S2_DEC_FAST - 1)
                    : decim_pkg::CNT_W'(decim_pkg::S2_DEC_SLOW - 1);
  assign s_last[2]  = decim_pkg::CNT_W'(decim_pkg::S3_DEC - 1);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_stage
      decim_stage u_stage (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (clr),
        .last      (s_last[g]),
        .in_valid  (s_valid[g]),
        .in_data   (s_data[g]),
        .out_valid (s_valid[g+1]),
        .out_data  (s_data[g+1])
      );
    end
  endgenerate

  // gain normalise: sum grows by mod_w + log2(ratio); shift up to fill the 24-bit result
  logic signed [decim_pkg::ACC_W-1:0] scaled;
  always_comb begin
    if (dec128_r)
      scaled = s_data[3] <<< (decim_pkg::OUT_W - decim_pkg::MOD_W - 7);
    else
      scaled = s_data[3] <<< (decim_pkg::OUT_W - decim_pkg::MOD_W - 8);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_valid <= 1'b0;
      result_data  <= '0;
    end else begin
      result_valid <= s_valid[3] && !clr;
      if (s_valid[3] && !clr)
        result_data <= scaled[decim_pkg::OUT_W-1:0];
    end
  end

  // settle counter in master clock periods
  logic [decim_pkg::SETTLE_W-1:0] settle_cnt_r;
  logic [decim_pkg::SETTLE_W-1:0] settle_target;
  logic                           ovr_now;
  assign ovr_now = ovr_s_r[1];
  assign settle_target = dec128_r
                       ? decim_pkg::SETTLE_W'(decim_pkg::SETTLE_128)
                       : decim_pkg::SETTLE_W'(decim_pkg::SETTLE_256);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_r        <= '0;
      filter_settled_flag <= 1'b0;
    end else if (clr || ovr_now) begin
      settle_cnt_r        <= '0;
      filter_settled_flag <= 1'b0;
    end else if (mclk_en && !filter_settled_flag) begin
      if (settle_cnt_r == settle_target - 1'b1)
        filter_settled_flag <= 1'b1;
      settle_cnt_r <= settle_cnt_r + 1'b1;
    end
  end

  // sticky events, write one to clear; set beats clear
  logic                           settled_d_r;
  logic [decim_pkg::IRQ_W-1:0]    irq_stat_r;
  logic [decim_pkg::IRQ_W-1:0]    irq_mask_r;
  logic [decim_pkg::IRQ_W-1:0]    ev;
  logic [decim_pkg::IRQ_W-1:0]    w1c;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      settled_d_r <= 1'b0;
    else
      settled_d_r <= filter_settled_flag;
  end

  always_comb begin
    ev = '0;
    ev[decim_pkg::IRQ_DRDY]   = result_valid;
    ev[decim_pkg::IRQ_SETTLE] = filter_settled_flag && !settled_d_r;
    ev[decim_pkg::IRQ_OVR]    = ovr_now;
  end

  assign w1c = (apb_wr && paddr == decim_pkg::IRQ_OFS)
             ? pwdata[decim_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_mask_r <= '0;
    else if (apb_wr && paddr == decim_pkg::MASK_OFS)
      irq_mask_r <= pwdata[decim_pkg::IRQ_W-1:0];
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // apb read, zero wait states
  logic addr_ok;
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      decim_pkg::CTRL_OFS: prdata = {31'h0, lpwr_r};
      decim_pkg::STAT_OFS: prdata = {28'h0, ovr_now, lpwr_r, dec128_r,
                                     filter_settled_flag};
      decim_pkg::MASK_OFS: prdata = {29'h0, irq_mask_r};
      decim_pkg::DATA_OFS: prdata = {8'h0, result_data};
      decim_pkg::IRQ_OFS:  prdata = {29'h0, irq_stat_r};
      default: begin
        prdata  = 32'h0;
        addr_ok = 1'b0;
      end
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
endmodule : decim_chain

//--- design/decim_stage.sv
// one boxcar decimation stage: accumulate ratio inputs, emit the sum
// assumes in_valid is a one-cycle strobe on pclk; clr restarts the phase
module decim_stage (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           clr,
  // ratio minus one
  input  wire logic [decim_pkg::CNT_W-1:0]    last,
  // stream in
  input  wire logic                           in_valid,
  input  wire logic signed [decim_pkg::ACC_W-1:0] in_data,
  // stream out
  output logic                                out_valid,
  output logic signed [decim_pkg::ACC_W-1:0]  out_data
);
  logic [decim_pkg::CNT_W-1:0]          phase_r;
  logic signed [decim_pkg::ACC_W-1:0]   acc_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= '0;
      acc_r   <= '0;
    end else if (clr) begin
      phase_r <= '0;
      acc_r   <= '0;
    end else if (in_valid) begin
      if (phase_r == last) begin
        phase_r <= '0;
        acc_r   <= '0;
      end else begin
        phase_r <= phase_r + 1'b1;
        acc_r   <= acc_r + in_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= in_valid && (phase_r == last) && !clr;
      if (in_valid && (phase_r == last))
        out_data <= acc_r + in_data;
    end
  end
endmodule : decim_stage

//--- design/internal_modulator_clock_gen.sv
// internal modulator clock enable from the master clock enable
// assumes mclk_en is a one-cycle pulse per master clock period
module internal_modulator_clock_gen (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clr,
  // mode
  input  wire logic low_power,
  input  wire logic mclk_en,
  // enable out
  output logic      internal_modulator_clock_en
);
  logic [1:0] div_r;
  logic [1:0] last;

  // low power halves the modulator rate again
  assign last = low_power ? 2'(decim_pkg::INTERNAL_MODULATOR_CLOCK_DIV_LOW - 1)
                          : 2'(decim_pkg::INTERNAL_MODULATOR_CLOCK_DIV_NORM - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else if (clr) begin
      div_r <= '0;
    end else if (mclk_en) begin
      div_r <= (div_r >= last) ? 2'd0 : div_r + 2'd1;
    end
  end

  assign internal_modulator_clock_en = mclk_en && (div_r >= last);
endmodule : internal_modulator_clock_gen

//--- tb/decim_chain_assertions.sv
// port assertions for the decimation chain
// bound into decim_chain below; single pclk domain
module decim_chain_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // pins
  input wire logic        reset_powerdown_n,
  input wire logic        sync_n,
  input wire logic        overrange,
  // results
  input wire logic        result_valid,
  input wire logic [decim_pkg::OUT_W-1:0] result_data,
  input wire logic        filter_settled_flag,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // restarts on sync or powerdown pin low, so the first result also needs a full window
  logic [10:0] gap_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= '0;
    end else if (!sync_n || !reset_powerdown_n || result_valid) begin
      gap_r <= '0;
    end else if (gap_r != 11'h7ff) begin
      gap_r <= gap_r + 11'h001;
    end
  end
  property p_pulse; result_valid |=> !result_valid; endproperty
  a_pulse: assert property (p_pulse)
    else $error("valid longer than one cycle");
  property p_hold; $changed(result_data) |-> result_valid; endproperty
  a_hold: assert property (p_hold)
    else $error("result changed without valid");
  property p_gap; result_valid |-> gap_r >= 11'h0ff; endproperty
  a_gap: assert property (p_gap)
    else $error("results too close");
  property p_sync; $fell(sync_n) |-> ##[1:6] !filter_settled_flag;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync did not clear settle flag");
  property p_ovr; overrange [*5] |-> !filter_settled_flag; endproperty
  a_ovr: assert property (p_ovr)
    else $error("flag high during overrange");
  property p_pdown;
    !reset_powerdown_n [*4] |-> !filter_settled_flag && !result_valid;
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("activity during powerdown");
  property p_unmapped; psel && penable && paddr > 8'h10 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("wait state inserted");
endmodule : decim_chain_assertions

bind decim_chain decim_chain_assertions i_decim_chain_assertions (
  .pclk(pclk), .presetn(presetn), .reset_powerdown_n(reset_powerdown_n),
  .sync_n(sync_n), .overrange(overrange), .result_valid(result_valid),
  .result_data(result_data), .filter_settled_flag(filter_settled_flag),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr));

//--- tb/mod_model.sv
// multibit modulator stand-in: master clock enable and held words
// assumes the bench sets the word level; pclk is twice the master rate
module mod_model (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // level to convert
  input  wire logic signed [7:0] level,
  // to the filter
  output logic                   mclk_en,
  output logic signed [7:0]      mod_data
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_en  <= 1'b0;
      mod_data <= 8'sh00;
    end else begin
      mclk_en  <= !mclk_en;
      mod_data <= level;
    end
  end
endmodule : mod_model

//--- tb/tb.sv
// bench for the decimation chain: settle, rates, values, irq, apb
// modulator model feeds words; the bench is the apb master
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic              pclk, presetn, reset_powerdown_n, sync_n, mclk_en;
  logic              decimation_select, overrange, irq;
  logic              psel, penable, pwrite, pready, pslverr;
  logic              result_valid, filter_settled_flag;
  logic              internal_modulator_clock;
  logic signed [7:0] level, mod_data;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [23:0]       result_data;
  int                num_errors, checks, cyc;
  mod_model i_mod_model (.pclk(pclk), .presetn(presetn), .level(level),
    .mclk_en(mclk_en), .mod_data(mod_data));
  decim_chain i_decim_chain (.pclk(pclk), .presetn(presetn),
    .reset_powerdown_n(reset_powerdown_n), .sync_n(sync_n),
    .decimation_select(decimation_select), .overrange(overrange),
    .mclk_en(mclk_en), .mod_data(mod_data), .result_valid(result_valid),
    .result_data(result_data), .filter_settled_flag(filter_settled_flag),
    .internal_modulator_clock(internal_modulator_clock), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  task automatic chk(input string n, input logic [31:0] s, x);
    checks++;
    if (s !== x) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    chk("pslverr", pslverr, e);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_v;
    // sample away from the launching edge
    do @(negedge pclk); while (result_valid !== 1'b1);
  endtask : wait_v
  task automatic settle(input int x);
    int n;
    n = 0;
    sync_n <= 1'b0;
    repeat (4) @(posedge pclk);
    sync_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("flag", filter_settled_flag, 1'b0);
    while (filter_settled_flag !== 1'b1) begin
      @(posedge pclk);
      n += mclk_en;
    end
    // a few pulses pass after the clear, before the bench starts counting
    chk("settle", n >= x - 8 && n <= x - 2, 1'b1);
  endtask : settle
  task automatic gap(input int x, t);
    int n, k;
    logic p;
    wait_v;
    n = 0;
    k = 0;
    p = internal_modulator_clock;
    do begin
      @(negedge pclk);
      n++;
      k += (internal_modulator_clock !== p);
      p = internal_modulator_clock;
    end while (result_valid !== 1'b1);
    chk("gap", n, x);
    chk("internal_modulator_clock", k, t);
  endtask : gap
  task automatic t_regs;
    repeat (4) @(posedge pclk);
    apb(0, decim_pkg::STAT_OFS, 0, 0);
    chk("stat", q, 32'h2);
    apb(1, decim_pkg::STAT_OFS, 32'hf, 0);
    apb(0, decim_pkg::STAT_OFS, 0, 0);
    chk("stat ro", q, 32'h2);
    apb(0, decim_pkg::MASK_OFS, 0, 0);
    chk("mask", q, 32'h0);
    apb(0, 8'h40, 0, 1);
    chk("unmapped", q, 32'h0);
  endtask : t_regs
  task automatic t_settle128;
    settle(14217);
    repeat (2) wait_v;
    chk("data", result_data, 32'h400000);
    level <= 8'shc0;
    repeat (4) wait_v;
    chk("data", result_data, 32'hc00000);
    gap(512, 128);
  endtask : t_settle128
  task automatic t_irq;
    apb(1, decim_pkg::IRQ_OFS, 32'h7, 0);
    apb(1, decim_pkg::MASK_OFS, 32'h1, 0);
    wait_v;
    repeat (2) @(posedge pclk);
    chk("irq", irq, 1'b1);
    apb(1, decim_pkg::MASK_OFS, 32'h0, 0);
    chk("irq masked", irq, 1'b0);
    apb(0, decim_pkg::IRQ_OFS, 0, 0);
    chk("sticky", q[0], 1'b1);
    apb(1, decim_pkg::IRQ_OFS, 32'h1, 0);
    apb(0, decim_pkg::IRQ_OFS, 0, 0);
    chk("w1c", q[0], 1'b0);
  endtask : t_irq
  task automatic t_lowpower;
    apb(1, decim_pkg::CTRL_OFS, 32'h1, 0);
    repeat (2) wait_v;
    gap(1024, 128);
    apb(0, decim_pkg::STAT_OFS, 0, 0);
    chk("lpwr", q[2], 1'b1);
    apb(1, decim_pkg::CTRL_OFS, 32'h0, 0);
  endtask : t_lowpower
  task automatic t_rate256;
    decimation_select <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(0, decim_pkg::STAT_OFS, 0, 0);
    chk("dec held", q[1], 1'b1);
    settle(27895);
    apb(0, decim_pkg::STAT_OFS, 0, 0);
    chk("stat", q, 32'h1);
    gap(1024, 256);
  endtask : t_rate256
  task automatic t_alarm;
    overrange <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("ovr flag", filter_settled_flag, 1'b0);
    apb(0, decim_pkg::IRQ_OFS, 0, 0);
    chk("ovr irq", q[2], 1'b1);
    overrange <= 1'b0;
    reset_powerdown_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("pdown", {result_valid, filter_settled_flag}, 2'b00);
    reset_powerdown_n <= 1'b1;
  endtask : t_alarm
  task automatic summarize;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // both settle waits dominate the run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 99000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, overrange} = '0;
    {reset_powerdown_n, sync_n, decimation_select} = '1;
    paddr = '0;
    pwdata = '0;
    level = 8'sh40;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_settle128;
    t_irq;
    t_lowpower;
    t_rate256;
    t_alarm;
    summarize;
  end
endmodule : tb
